// file: bench/sbk_flash_model.sv
// serial flash answering the master boot read
`timescale 1ns/100ps
module sbk_flash_model (
  input  wire        sck,
  input  wire        selN,
  input  wire        mosi,
  output reg         miso,
  output reg  [31:0] cmdWord
);
  // sent during the command, must be dropped
  localparam [31:0] JUNK = 32'h5A5A_C3C3;
  integer    bitNum;
  reg [31:0] cur;
  // raw kernel words, no block headers here
  function [31:0] img(input integer w);
    img = 32'h8421_0F30 + w * 32'h0101_0101;
  endfunction
  initial begin
    bitNum  = 0;
    miso    = 1'b1;
    cmdWord = 32'h0000_0000;
  end
  always @(negedge sck) begin
    if (!selN) begin
      cur  = (bitNum < 32) ? JUNK : img(bitNum / 32 - 1);
      miso = cur[bitNum % 32];
    end
  end
  always @(posedge sck) begin
    if (!selN) begin
      if (bitNum < 32) cmdWord[bitNum] = mosi;
      bitNum = bitNum + 1;
    end
  end
  // released line must not keep a valid look
  always @(posedge selN) miso = ~miso;
  always @(negedge selN) bitNum = 0;
endmodule // sbk_flash_model

// file: bench/sbk_loader_asserts.sv
// concurrent checks on the boot loader ports
`timescale 1ns/100ps
module sbk_loader_chk #(
  parameter DMA_WORDS = 384
) (
  input wire        clk,
  input wire        resetn,
  input wire [1:0]  bootConfig,
  input wire        serialClockOut,
  input wire        serialClockOe,
  input wire        bootSelectOut,
  input wire        misoOe,
  input wire [9:0]  serialControl,
  input wire        dmaValid,
  input wire [31:0] dmaData,
  input wire [8:0]  dmaAddr,
  input wire        dmaReady,
  input wire [8:0]  dmaCount,
  input wire        bootActive,
  input wire        masterMode
);
  localparam [8:0] CNT = DMA_WORDS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  reg [8:0] lastAddr_ff;
  reg       took_ff;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lastAddr_ff <= 9'h000;
      took_ff     <= 1'b0;
    end else if (dmaValid && dmaReady) begin
      lastAddr_ff <= dmaAddr;
      took_ff     <= 1'b1;
    end
  end
  chk_addr_order: assert property (
    dmaValid |-> dmaAddr == (took_ff ? lastAddr_ff + 9'h001 : 9'h000))
    else $error("dma address out of order");
  chk_dma_hold: assert property (
    dmaValid && !dmaReady |=> dmaValid && $stable(dmaData)
      && $stable(dmaAddr))
    else $error("dma word not held");
  chk_ctl_slave: assert property (
    bootActive && $past(bootActive) && !masterMode
      |-> serialControl == 10'h3B1)
    else $error("slave control image wrong");
  chk_bit_order: assert property (
    serialControl[2] == 1'b0)
    else $error("bit order not lsb first");
  chk_dma_count: assert property (
    bootActive && $past(bootActive) |-> dmaCount == CNT)
    else $error("dma count wrong");
  chk_mode_pick: assert property (
    bootActive && $past(bootActive)
      |-> masterMode == (bootConfig == 2'b01))
    else $error("boot mode does not match strap");
  chk_select_low: assert property (
    !serialClockOut |-> !bootSelectOut && serialClockOe)
    else $error("clock runs without select");
  chk_clock_div: assert property (
    $fell(serialClockOut) |-> !serialClockOut[*4])
    else $error("serial clock low phase short");
  chk_miso_off: assert property (
    misoOe == 1'b0)
    else $error("miso driven");
endmodule // sbk_loader_chk

bind sbk_boot_loader sbk_loader_chk #(.DMA_WORDS(DMA_WORDS)) chk_u (
  .clk, .resetn, .bootConfig, .serialClockOut, .serialClockOe,
  .bootSelectOut, .misoOe, .serialControl, .dmaValid, .dmaData,
  .dmaAddr, .dmaReady, .dmaCount, .bootActive, .masterMode
);

// file: bench/tb.sv
// testbench for the serial boot loader
`timescale 1ns/100ps
module tb;
  reg         clk;
  reg         resetn;
  reg  [1:0]  bootConfig;
  reg         kernelDone;
  reg         sckIn;
  reg         selIn;
  reg         mosiIn;
  reg         dmaReady;
  wire        misoIn;
  wire        sckOut;
  wire        sckOe;
  wire        selOut;
  wire        mosiOut;
  wire [9:0]  serialControl;
  wire        dmaValid;
  wire [31:0] dmaData;
  wire [8:0]  dmaAddr;
  wire [8:0]  dmaCount;
  wire        bootActive;
  wire        masterMode;
  wire        kernelLoaded;
  wire [31:0] cmdWord;
  wire        sckWire = sckOe ? sckOut : sckIn;
  integer     badCount;
  integer     checked;
  integer     i;
  integer     k;
  reg  [31:0] q;
  sbk_boot_loader dut_u (
    .clk(clk), .resetn(resetn), .bootConfig(bootConfig),
    .kernelDone(kernelDone), .serialClockIn(sckWire),
    .slaveSelectIn(selIn), .mosiIn(mosiIn), .misoIn(misoIn),
    .serialClockOut(sckOut), .serialClockOe(sckOe),
    .bootSelectOut(selOut), .mosiOut(mosiOut), .mosiOe(), .misoOut(),
    .misoOe(), .serialControl(serialControl), .dmaValid(dmaValid),
    .dmaData(dmaData), .dmaAddr(dmaAddr), .dmaReady(dmaReady),
    .dmaCount(dmaCount), .kernelLoaded(kernelLoaded),
    .bootActive(bootActive),
    .masterMode(masterMode)
  );
  sbk_flash_model flash_u (
    .sck(sckWire), .selN(selOut), .mosi(mosiOut), .miso(misoIn),
    .cmdWord(cmdWord)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        badCount = badCount + 1;
        $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task stopTest;
    begin
      $display("checks %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task hang;
    begin
      cmp(32'h0000_0000, 32'h0000_0001);
      stopTest;
    end
  endtask
  task boot(input [1:0] cfg);
    begin
      @(posedge clk);
      resetn     <= 1'b0;
      bootConfig <= cfg;
      dmaReady   <= 1'b0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      for (i = 0; i < 50 && bootActive !== 1'b1; i = i + 1) @(negedge clk);
      if (i == 50) hang;
      repeat (4) @(negedge clk);
    end
  endtask
  // one word from the dma port, sampled mid-cycle
  task getWord(input integer w);
    begin
      i = 0;
      @(negedge clk);
      while (dmaValid !== 1'b1 && i < 4000) begin
        @(negedge clk);
        i = i + 1;
      end
      if (i == 4000) hang;
      cmp({23'h0, dmaAddr}, w);
      cmp(dmaData, flash_u.img(w));
    end
  endtask
  // length of the current run of an unchanged serial clock, stopping once it reaches n
  task quiet(input integer n, input integer lim, output [31:0] r);
    reg last;
    begin
      r = 0;
      last = sckOut;
      for (i = 0; i < lim && r < n; i = i + 1) begin
        @(negedge clk);
        r = (sckOut === last) ? r + 1 : 0;
        last = sckOut;
      end
    end
  endtask
  // host sends lsb first, no bit reversal
  // host cannot be stalled, so words go out at full rate
  task hostWord(input [31:0] w);
    integer b;
    begin
      for (b = 0; b < 32; b = b + 1) begin
        @(posedge clk);
        sckIn  <= 1'b0;
        mosiIn <= w[b];
        repeat (4) @(posedge clk);
        sckIn <= 1'b1;
        repeat (3) @(posedge clk);
      end
    end
  endtask
  task testSlave;
    begin
      boot(2'b00);
      cmp({22'h0, serialControl}, 32'h0000_03B1);
      cmp({23'h0, dmaCount}, 32'h0000_0180);
      cmp({31'h0, masterMode}, 32'h0000_0000);
      @(posedge clk);
      selIn <= 1'b0;
      for (k = 0; k < 3; k = k + 1) hostWord(flash_u.img(k));
      @(posedge clk);
      selIn    <= 1'b1;
      dmaReady <= 1'b1;
      for (k = 0; k < 3; k = k + 1) getWord(k);
      cmp({31'h0, kernelLoaded}, 32'h0000_0000);
      $display("test slave done");
    end
  endtask
  task testMaster;
    begin
      boot(2'b01);
      cmp({31'h0, masterMode}, 32'h0000_0001);
      quiet(64, 8000, q);
      cmp(q, 32'h0000_0040);
      if (q != 64) stopTest;
      cmp(cmdWord, 32'h0000_00C0);
      @(posedge clk);
      dmaReady <= 1'b1;
      for (k = 0; k < 8; k = k + 1) getWord(k);
      quiet(8, 200, q);
      cmp({31'h0, q < 5}, 32'h0000_0001);
      @(posedge clk);
      kernelDone <= 1'b1;
      quiet(64, 2000, q);
      cmp(q, 32'h0000_0040);
      $display("test master done");
    end
  endtask
  initial begin
    resetn     = 1'b0;
    bootConfig = 2'b00;
    kernelDone = 1'b0;
    sckIn      = 1'b1;
    selIn      = 1'b1;
    mosiIn     = 1'b0;
    dmaReady   = 1'b0;
    badCount   = 0;
    checked    = 0;
    testSlave;
    testMaster;
    stopTest;
  end
endmodule // tb

// file: verilog/sbk_boot_loader.v
// serial boot kernel loader: slave and master boot over the serial port
// Functional notes
// - load kernel with 256-instruction boot dma
// - receive shift word fixed at 32 bits
// - narrow sources packed lsb first into words
// - slave boot dma count is 384 words
// - slave boot control field settings fixed
// - slave boot polarity and phase both one
// - master boot: run clock, drive select low
// - master sends read 0x03 plus zero address
// - command is one word sent lsb first, so opcode 0x03 goes out msb first
// - word received during command is discarded
// - first boot bit at serial clock 32
// - keep clocking until kernel finishes loading
// - bit order bit resets to lsb first
// - cfg 00 slave boot, 01 master boot
`timescale 1ns/100ps
`include "sbk_map.vh"
module sbk_boot_loader #(
  parameter CLK_DIV   = `SBK_CLK_DIV,
  parameter DMA_WORDS = `SBK_SLAVE_DMA_CNT,
  parameter FIFO_DEPTH = 4
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire [1:0]  bootConfig,
  input  wire        kernelDone,
  input  wire        serialClockIn,
  input  wire        slaveSelectIn,
  input  wire        mosiIn,
  input  wire        misoIn,
  output reg         serialClockOut,
  output reg         serialClockOe,
  output reg         bootSelectOut,
  output reg         mosiOut,
  output reg         mosiOe,
  output reg         misoOut,
  output reg         misoOe,
  output reg  [9:0]  serialControl,
  output reg         dmaValid,
  output reg  [31:0] dmaData,
  output reg  [8:0]  dmaAddr,
  input  wire        dmaReady,
  output reg  [8:0]  dmaCount,
  output reg         kernelLoaded,
  output reg         bootActive,
  output reg         masterMode
);
  localparam ST_IDLE   = 5'b00001;
  localparam ST_SLAVE  = 5'b00010;
  localparam ST_CMD    = 5'b00100;
  localparam ST_STREAM = 5'b01000;
  localparam ST_DONE   = 5'b10000;

  reg [4:0]  state_ff;
  reg [4:0]  nxt_state;
  reg [1:0]  cfgSync1_ff;
  reg [1:0]  cfgSync2_ff;
  reg        started_ff;
  reg [2:0]  sclkSync_ff;
  reg [2:0]  ssSync_ff;
  reg [1:0]  mosiSync_ff;
  reg [1:0]  misoSync_ff;
  reg [7:0]  divCnt_ff;
  reg [31:0] shift_ff;
  reg [5:0]  bitCnt_ff;
  reg [31:0] txShift_ff;
  reg        wordValid_ff;
  reg [31:0] wordData_ff;
  reg [8:0]  dmaCnt_ff;
  reg        dmaPending_ff;

  wire       sclkRise;
  wire       ssFall;
  wire       ssLow;
  wire       divTick;
  wire       masterRise;
  wire       sampleTick;
  wire       sampleBit;
  wire       lastBit;
  wire       fifoInReady;
  wire       fifoOutValid;
  wire [31:0] fifoOutData;
  wire       fifoPop;
  wire       dmaFull;

  // host clock is active low idle high; sample on rising edge
  assign sclkRise  = sclkSync_ff[1] & ~sclkSync_ff[2];
  assign ssFall    = ~ssSync_ff[1] & ssSync_ff[2];
  assign ssLow     = ~ssSync_ff[1];
  assign divTick   = (divCnt_ff == CLK_DIV[7:0] - 8'h01);
  assign masterRise = divTick & ~serialClockOut;
  assign sampleTick = (state_ff == ST_SLAVE) ? (sclkRise & ssLow) :
                      (masterRise & fifoInReady);
  assign sampleBit = (state_ff == ST_SLAVE) ? mosiSync_ff[1] :
                     misoSync_ff[1];
  assign lastBit   = (bitCnt_ff == 6'd31);
  assign dmaFull   = (dmaCnt_ff == DMA_WORDS[8:0]);
  assign fifoPop   = fifoOutValid & (!dmaPending_ff | dmaReady) & !dmaFull;

  sbk_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (wordValid_ff),
    .inReady  (fifoInReady),
    .inData   (wordData_ff),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (started_ff && cfgSync2_ff == `SBK_CFG_SLAVE) begin
          nxt_state = ST_SLAVE;
        end else if (started_ff && cfgSync2_ff == `SBK_CFG_MASTER) begin
          nxt_state = ST_CMD;
        end
      end
      ST_SLAVE: begin
        if (dmaFull) begin
          nxt_state = ST_DONE;
        end
      end
      ST_CMD: begin
        if (sampleTick && lastBit) begin
          nxt_state = ST_STREAM;
        end
      end
      ST_STREAM: begin
        // run until kernel done
        // stop only in a high phase so no low phase is cut short
        if (kernelDone && serialClockOut && !divTick) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: nxt_state = ST_DONE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff      <= ST_IDLE;
      cfgSync1_ff   <= 2'b11;
      cfgSync2_ff   <= 2'b11;
      started_ff    <= 1'b0;
      sclkSync_ff   <= 3'b111;
      ssSync_ff     <= 3'b111;
      mosiSync_ff   <= 2'b00;
      misoSync_ff   <= 2'b00;
      divCnt_ff     <= 8'h00;
      shift_ff      <= 32'h0000_0000;
      bitCnt_ff     <= 6'd0;
      txShift_ff    <= 32'h0000_0000;
      wordValid_ff  <= 1'b0;
      wordData_ff   <= 32'h0000_0000;
      dmaCnt_ff     <= 9'd0;
      dmaPending_ff <= 1'b0;
      serialClockOut <= 1'b1;
      serialClockOe <= 1'b0;
      bootSelectOut <= 1'b1;
      mosiOut       <= 1'b0;
      mosiOe        <= 1'b0;
      misoOut       <= 1'b0;
      misoOe        <= 1'b0;
      serialControl <= 10'h000;
      dmaValid      <= 1'b0;
      dmaData       <= 32'h0000_0000;
      dmaAddr       <= 9'd0;
      dmaCount      <= 9'd0;
      kernelLoaded  <= 1'b0;
      bootActive    <= 1'b0;
      masterMode    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      // strap caught after release, two stages since it is a pin
      cfgSync1_ff <= bootConfig;
      cfgSync2_ff <= cfgSync1_ff;
      started_ff  <= 1'b1;
      sclkSync_ff <= {sclkSync_ff[1:0], serialClockIn};
      ssSync_ff   <= {ssSync_ff[1:0], slaveSelectIn};
      mosiSync_ff <= {mosiSync_ff[0], mosiIn};
      misoSync_ff <= {misoSync_ff[0], misoIn};
      wordValid_ff <= 1'b0;
      bootActive  <= (nxt_state == ST_SLAVE) || (nxt_state == ST_CMD) ||
                     (nxt_state == ST_STREAM);
      if (state_ff == ST_IDLE && nxt_state == ST_SLAVE) begin
        serialControl[`SBK_CTL_ENABLE]   <= 1'b1;
        serialControl[`SBK_CTL_MASTER]   <= 1'b0;
        serialControl[`SBK_CTL_ORDER]    <= 1'b0;
        serialControl[`SBK_CTL_LEN_LO+1:`SBK_CTL_LEN_LO] <= `SBK_LEN_32;
        serialControl[`SBK_CTL_MISO_DIS] <= 1'b1;
        serialControl[`SBK_CTL_SEND_ZERO] <= 1'b0;
        serialControl[`SBK_CTL_RCV_DMA]  <= 1'b1;
        serialControl[`SBK_CTL_POLARITY] <= 1'b1;
        serialControl[`SBK_CTL_PHASE]    <= 1'b1;
        dmaCount <= DMA_WORDS[8:0];
      end
      if (state_ff == ST_IDLE && nxt_state == ST_CMD) begin
        serialControl <= 10'h000;
        serialControl[`SBK_CTL_ENABLE]  <= 1'b1;
        serialControl[`SBK_CTL_MASTER]  <= 1'b1;
        serialControl[`SBK_CTL_LEN_LO+1:`SBK_CTL_LEN_LO] <= `SBK_LEN_32;
        serialControl[`SBK_CTL_RCV_DMA] <= 1'b1;
        serialControl[`SBK_CTL_POLARITY] <= 1'b1;
        serialControl[`SBK_CTL_PHASE]   <= 1'b1;
        txShift_ff    <= `SBK_READ_CMD;
        masterMode    <= 1'b1;
        dmaCount      <= DMA_WORDS[8:0];
        bootSelectOut <= 1'b0;
        serialClockOe <= 1'b1;
        mosiOe        <= 1'b1;
      end
      // a new select fall restarts word framing
      if (state_ff == ST_SLAVE && ssFall) begin
        bitCnt_ff <= 6'd0;
      end
      if (state_ff == ST_CMD || state_ff == ST_STREAM) begin
        // clock pauses while fifo is full, so no bit is dropped
        if (divTick && (serialClockOut == 1'b0 || fifoInReady)) begin
          divCnt_ff      <= 8'h00;
          serialClockOut <= ~serialClockOut;
          if (serialClockOut) begin
            mosiOut    <= txShift_ff[0];
            txShift_ff <= {1'b0, txShift_ff[31:1]};
          end
        end else if (!divTick) begin
          divCnt_ff <= divCnt_ff + 8'h01;
        end
      end
      if ((state_ff == ST_SLAVE || state_ff == ST_CMD ||
           state_ff == ST_STREAM) && sampleTick &&
          !(state_ff == ST_SLAVE && ssFall)) begin
        shift_ff  <= {sampleBit, shift_ff[31:1]};
        bitCnt_ff <= lastBit ? 6'd0 : bitCnt_ff + 6'd1;
        if (lastBit && state_ff != ST_CMD) begin
          wordValid_ff <= 1'b1;
          wordData_ff  <= {sampleBit, shift_ff[31:1]};
        end
      end
      if (state_ff == ST_DONE) begin
        serialClockOut <= 1'b1;
        bootSelectOut  <= 1'b1;
        serialClockOe  <= 1'b0;
        mosiOe         <= 1'b0;
      end
      if (dmaValid && dmaReady) begin
        dmaValid      <= 1'b0;
        dmaPending_ff <= 1'b0;
      end
      if (fifoPop) begin
        dmaValid      <= 1'b1;
        dmaPending_ff <= 1'b1;
        dmaData       <= fifoOutData;
        dmaAddr       <= dmaCnt_ff;
        dmaCnt_ff     <= dmaCnt_ff + 9'd1;
      end
      kernelLoaded <= dmaFull & !dmaPending_ff;
    end
  end
endmodule // sbk_boot_loader

// file: verilog/sbk_fifo.v
// small word fifo between shifter and boot dma
`timescale 1ns/100ps
module sbk_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output reg  [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wrPtr_ff;
  reg [AW:0]      rdPtr_ff;
  reg             outValid_ff;
  wire [AW:0]     level;
  wire            doWrite;
  wire            doRead;
  wire            memEmpty;

  assign level    = wrPtr_ff - rdPtr_ff;
  assign memEmpty = (level == {(AW+1){1'b0}});
  assign inReady  = (level != DEPTH[AW:0]);
  assign doWrite  = inValid & inReady;
  assign doRead   = !memEmpty & (!outValid_ff | outReady);
  assign outValid = outValid_ff;

  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_ff    <= {(AW+1){1'b0}};
      rdPtr_ff    <= {(AW+1){1'b0}};
      outValid_ff <= 1'b0;
      outData     <= {WIDTH{1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doRead) begin
        outData     <= mem[rdPtr_ff[AW-1:0]];
        rdPtr_ff    <= rdPtr_ff + 1'b1;
        outValid_ff <= 1'b1;
      end else if (outReady) begin
        outValid_ff <= 1'b0;
      end
    end
  end
endmodule // sbk_fifo

// file: verilog/sbk_map.vh
// constants for the serial boot kernel loader
`ifndef SBK_MAP_VH
`define SBK_MAP_VH
`define SBK_CFG_SLAVE      2'b00
`define SBK_CFG_MASTER     2'b01
`define SBK_WORD_BITS      32
`define SBK_KERNEL_INSTR   256
`define SBK_SLAVE_DMA_CNT  384
`define SBK_READ_CMD       32'h0000_00C0
`define SBK_LEN_32         2'b10
`define SBK_CLK_DIV        4
`define SBK_CTL_ENABLE     0
`define SBK_CTL_MASTER     1
`define SBK_CTL_ORDER      2
`define SBK_CTL_LEN_LO     3
`define SBK_CTL_MISO_DIS   5
`define SBK_CTL_SEND_ZERO  6
`define SBK_CTL_RCV_DMA    7
`define SBK_CTL_POLARITY   8
`define SBK_CTL_PHASE      9
`endif
